//--- design/power_mode_params.svh
// Constants of the power mode supervisor: register offsets, fields, timing.
// Assumes inclusion by bare name; no processes here.
`ifndef POWER_MODE_PARAMS_SVH
`define POWER_MODE_PARAMS_SVH

`define PM_ADDR_W          4
`define PM_DATA_W          32
`define PM_OFF_CONTROL     4'h0
`define PM_OFF_STATUS      4'h4
`define PM_OFF_IRQ_STATUS  4'h8
`define PM_OFF_IRQ_CLEAR   4'hc
// Control register fields
`define PM_CTL_DETECT_EN   0
`define PM_CTL_RISE_EN     1
`define PM_CTL_FALL_EN     2
`define PM_CTL_STOP_LP     3
`define PM_CTL_MODE_LO     4
`define PM_CTL_MODE_HI     5
`define PM_CTL_ENTER       6
`define PM_CTL_IRQ_EN_LO   8
// Interrupt status bits
`define PM_IRQ_FALL        0
`define PM_IRQ_RISE        1
`define PM_IRQ_WAKE        2
`define PM_IRQ_W           3
// Mode request codes
`define PM_REQ_SLEEP       2'h1
`define PM_REQ_STOP        2'h2
`define PM_REQ_STANDBY     2'h3
// Timing and event line count
`define PM_RESET_HOLD_NS   100
`define PM_CLK_PERIOD_NS   5
`define PM_RESET_HOLD_CYC  ((`PM_RESET_HOLD_NS + `PM_CLK_PERIOD_NS - 1) / `PM_CLK_PERIOD_NS)
`define PM_EVT_LINES       16

`endif

//--- design/power_mode_pkg.sv
// Types of the power mode supervisor.
// Needs nothing from the params header; the state width is fixed at six bits.
package power_mode_pkg;
  typedef enum logic [5:0] {
    S_RESET   = 6'b000001,
    S_RUN     = 6'b000010,
    S_SLEEP   = 6'b000100,
    S_STOP    = 6'b001000,
    S_STANDBY = 6'b010000,
    S_WAKE    = 6'b100000
  } pm_state_t;
endpackage

//--- design/pm_sync_if.sv
// Interface carrying synchronised inputs from the synchroniser to the top.
// Assumes one clock domain.
`timescale 1ns/1ps
interface pm_sync_if #(parameter int W = 8);
  logic [W-1:0] sync;
  modport src (output sync);
  modport dst (input  sync);
endinterface

//--- design/pm_sync.sv
// Two-stage synchroniser bank for asynchronous pins.
// Assumes inputs arrive from outside the clock domain.
`timescale 1ns/1ps
module pm_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] async_i,
  pm_sync_if.src            out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign out.sync = sync_ff;
endmodule // pm_sync

//--- design/pm_reset_hold.sv
// Reset stretcher: holds the reset output for a fixed count after the cause ends.
// Assumes cause input is already synchronous.
`timescale 1ns/1ps
`include "power_mode_params.svh"
module pm_reset_hold #(
  parameter int HOLD = `PM_RESET_HOLD_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic cause_i,
  output logic      hold_o
);
  localparam int CW = $clog2(HOLD + 1);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;

  always_comb begin
    if (cause_i) begin
      nxt_cnt = CW'(HOLD);
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt_ff <= CW'(HOLD);
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign hold_o = cause_i || (cnt_ff != '0);
endmodule // pm_reset_hold

//--- design/power_mode_supervisor.sv
// Power mode supervisor top: supply supervision, level detector interrupt, mode sequencing.
// Assumes analog comparators give digital levels on pins; registers on a plain strobe port.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "power_mode_params.svh"
module power_mode_supervisor #(
  parameter int EVT_LINES = `PM_EVT_LINES,
  parameter int HOLD      = `PM_RESET_HOLD_CYC
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     sys_rst_i,
  // Register port
  input  wire logic [`PM_ADDR_W-1:0]    addr_i,
  input  wire logic [`PM_DATA_W-1:0]    wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [`PM_DATA_W-1:0]    rdata_o,
  output logic                          irq_o,
  // Supply comparators, high when supply is above threshold; analog_monitor_off_i high masks the analog supply check
  input  wire logic                     main_supply_ok_i,
  input  wire logic                     analog_supply_ok_i,
  input  wire logic                     supply_level_detector_i,
  input  wire logic                     analog_monitor_off_i,
  // Processor side
  input  wire logic                     core_halt_i,
  // Wake sources
  input  wire logic [EVT_LINES-1:0]     external_event_controller_i,
  input  wire logic                     comparator_outputs_i,
  input  wire logic                     i2c_wake_i,
  input  wire logic                     serial_wake_i,
  input  wire logic                     calendar_alarm_i,
  input  wire logic                     external_reset_pin_n_i,
  input  wire logic                     independent_watchdog_i,
  input  wire logic                     wakeup_pin_i,
  input  wire logic                     core_irq_i,
  // Power and clock controls
  output logic                          core_reset_o,
  output logic                          cpu_clk_en_o,
  output logic                          core_clk_en_o,
  output logic                          pll_en_o,
  output logic                          internal_fast_oscillator_en_o,
  output logic                          external_fast_oscillator_en_o,
  output logic                          regulator_en_o,
  output logic                          regulator_main_mode_o,
  output logic                          regulator_lowpower_mode_o,
  output logic                          core_domain_power_o,
  output logic                          backup_domain_run_o,
  output logic [1:0]                    mode_o
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int SW = EVT_LINES + 12;
  pm_sync_if #(.W(SW)) sy ();
  pm_sync #(.W(SW)) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({external_event_controller_i, main_supply_ok_i, analog_supply_ok_i,
                 supply_level_detector_i, analog_monitor_off_i, comparator_outputs_i,
                 i2c_wake_i, serial_wake_i, calendar_alarm_i, external_reset_pin_n_i,
                 independent_watchdog_i, wakeup_pin_i, core_irq_i}),
    .out       (sy)
  );
  logic [EVT_LINES-1:0] s_lines;
  logic s_main, s_ana, s_lvl, s_anaoff, s_comp, s_i2c, s_ser, s_alarm, s_rst_n, s_wdg;
  logic s_wakeup_pin, s_irq;
  assign {s_lines, s_main, s_ana, s_lvl, s_anaoff, s_comp, s_i2c, s_ser, s_alarm, s_rst_n,
          s_wdg, s_wakeup_pin, s_irq} = sy.sync;

  // ****************************************
  // Supply supervision and reset
  // ****************************************
  logic por_ff, nxt_por;
  logic supply_fail;
  logic standby_exit;
  logic hold;
  always_comb begin
    // Power-on arms only from the main supply
    nxt_por = por_ff && !s_main;
  end
  // Power-down looks at both, analog part optional
  assign supply_fail = por_ff || !s_main || (!s_ana && !s_anaoff);

  pm_reset_hold #(.HOLD(HOLD)) u_hold (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .cause_i   (supply_fail || !s_rst_n || s_wdg || standby_exit),
    .hold_o    (hold)
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [`PM_DATA_W-1:0] ctl_ff, nxt_ctl;
  logic [`PM_IRQ_W-1:0]  ist_ff, nxt_ist;
  logic [`PM_DATA_W-1:0] rdata_ff, nxt_rdata;
  logic                  lvl_ff, nxt_lvl;
  logic                  wakeup_pin_ff, nxt_wakeup_pin;
  power_mode_pkg::pm_state_t state_ff, nxt_state;

  logic wr_ctl, wr_clr;
  logic lvl_fall, lvl_rise, wake_evt, stop_wake, standby_wake;
  logic [1:0] req_mode;
  logic enter_req;
  logic [`PM_IRQ_W-1:0] irq_en;

  always_comb begin
    wr_ctl = 1'b0;
    wr_clr = 1'b0;
    if (wr_i && addr_i == `PM_OFF_CONTROL) begin
      wr_ctl = 1'b1;
    end else if (wr_i && addr_i == `PM_OFF_IRQ_CLEAR) begin
      wr_clr = 1'b1;
    end
  end

  assign req_mode  = ctl_ff[`PM_CTL_MODE_HI:`PM_CTL_MODE_LO];
  assign enter_req = ctl_ff[`PM_CTL_ENTER];
  assign irq_en    = ctl_ff[`PM_CTL_IRQ_EN_LO +: `PM_IRQ_W];
  assign lvl_fall  = ctl_ff[`PM_CTL_DETECT_EN] && ctl_ff[`PM_CTL_FALL_EN] && lvl_ff && !s_lvl;
  assign lvl_rise  = ctl_ff[`PM_CTL_DETECT_EN] && ctl_ff[`PM_CTL_RISE_EN] && !lvl_ff && s_lvl;
  // Any event-controller line ends Stop, detector crossing included
  assign stop_wake = (|s_lines) || lvl_fall || lvl_rise || s_alarm || s_comp || s_i2c
                     || s_ser || s_irq;
  assign standby_wake = (s_wakeup_pin && !wakeup_pin_ff) || s_alarm || !s_rst_n || s_wdg;
  assign wake_evt  = (state_ff == power_mode_pkg::S_SLEEP && (s_irq || stop_wake))
                     || (state_ff == power_mode_pkg::S_STOP && stop_wake);

  always_comb begin
    nxt_ctl = ctl_ff;
    if (wr_ctl) begin
      nxt_ctl = wdata_i;
    end else if (state_ff != power_mode_pkg::S_RUN) begin
      // Request is consumed once the mode is taken
      nxt_ctl[`PM_CTL_ENTER] = 1'b0;
    end
    nxt_ist = ist_ff;
    if (wr_clr) begin
      nxt_ist = ist_ff & ~wdata_i[`PM_IRQ_W-1:0];
    end
    // Set wins over clear
    if (lvl_fall) nxt_ist[`PM_IRQ_FALL] = 1'b1;
    if (lvl_rise) nxt_ist[`PM_IRQ_RISE] = 1'b1;
    if (wake_evt) nxt_ist[`PM_IRQ_WAKE] = 1'b1;
    nxt_lvl  = s_lvl;
    nxt_wakeup_pin = s_wakeup_pin;
    nxt_rdata = '0;
    if (rd_i && addr_i == `PM_OFF_CONTROL) begin
      nxt_rdata = ctl_ff;
    end else if (rd_i && addr_i == `PM_OFF_STATUS) begin
      nxt_rdata = {24'h0, 2'h0, state_ff};
    end else if (rd_i && addr_i == `PM_OFF_IRQ_STATUS) begin
      nxt_rdata = {{(`PM_DATA_W-`PM_IRQ_W){1'b0}}, ist_ff};
    end
  end

  // ****************************************
  // Mode sequencer
  // ****************************************
  always_comb begin
    nxt_state    = state_ff;
    standby_exit = 1'b0;
    case (state_ff)
      power_mode_pkg::S_RESET: begin
        nxt_state = power_mode_pkg::S_RUN;
      end
      power_mode_pkg::S_RUN: begin
        // Only a software request followed by a halt enters low power
        if (core_halt_i && enter_req) begin
          if (req_mode == `PM_REQ_SLEEP) begin
            nxt_state = power_mode_pkg::S_SLEEP;
          end else if (req_mode == `PM_REQ_STOP) begin
            nxt_state = power_mode_pkg::S_STOP;
          end else if (req_mode == `PM_REQ_STANDBY) begin
            nxt_state = power_mode_pkg::S_STANDBY;
          end
        end
      end
      power_mode_pkg::S_SLEEP: begin
        if (s_irq || stop_wake) nxt_state = power_mode_pkg::S_WAKE;
      end
      power_mode_pkg::S_STOP: begin
        if (stop_wake) nxt_state = power_mode_pkg::S_WAKE;
      end
      power_mode_pkg::S_STANDBY: begin
        if (standby_wake) begin
          standby_exit = 1'b1;
          nxt_state    = power_mode_pkg::S_RESET;
        end
      end
      power_mode_pkg::S_WAKE: begin
        nxt_state = power_mode_pkg::S_RUN;
      end
      default: nxt_state = power_mode_pkg::S_RESET;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      por_ff   <= 1'b1;
      ctl_ff   <= '0;
      ist_ff   <= '0;
      rdata_ff <= '0;
      lvl_ff   <= 1'b0;
      wakeup_pin_ff  <= 1'b0;
      state_ff <= power_mode_pkg::S_RESET;
    end else begin
      por_ff   <= nxt_por;
      rdata_ff <= nxt_rdata;
      lvl_ff   <= nxt_lvl;
      wakeup_pin_ff  <= nxt_wakeup_pin;
      if (hold && state_ff != power_mode_pkg::S_STANDBY) begin
        ctl_ff   <= '0;
        ist_ff   <= '0;
        state_ff <= power_mode_pkg::S_RESET;
      end else begin
        ctl_ff   <= nxt_ctl;
        ist_ff   <= nxt_ist;
        state_ff <= nxt_state;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic in_stop, in_stby;
  assign in_stop = (state_ff == power_mode_pkg::S_STOP);
  assign in_stby = (state_ff == power_mode_pkg::S_STANDBY);

  assign rdata_o       = rdata_ff;
  assign irq_o         = |(ist_ff & irq_en);
  assign core_reset_o  = hold || (state_ff == power_mode_pkg::S_RESET);
  assign cpu_clk_en_o  = (state_ff == power_mode_pkg::S_RUN)
                         || (state_ff == power_mode_pkg::S_WAKE);
  assign core_clk_en_o = !in_stop && !in_stby;
  assign pll_en_o      = !in_stop && !in_stby;
  assign internal_fast_oscillator_en_o = !in_stop && !in_stby;
  assign external_fast_oscillator_en_o = !in_stop && !in_stby;
  assign regulator_en_o            = !in_stby;
  assign regulator_main_mode_o     = !in_stby && !(in_stop && ctl_ff[`PM_CTL_STOP_LP]);
  assign regulator_lowpower_mode_o = in_stop && ctl_ff[`PM_CTL_STOP_LP];
  assign core_domain_power_o       = !in_stby;
  assign backup_domain_run_o       = 1'b1;
  assign mode_o = in_stby ? `PM_REQ_STANDBY : in_stop ? `PM_REQ_STOP :
                  (state_ff == power_mode_pkg::S_SLEEP) ? `PM_REQ_SLEEP : 2'h0;
endmodule // power_mode_supervisor

//--- bench/pms_asserts.sv
// Port-level checks of the power mode supervisor.
// Assumes a bind from the bench top; one clock domain.
`timescale 1ns/1ps
module pms_asserts (
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire logic       main_supply_ok_i,
  input wire logic       analog_supply_ok_i,
  input wire logic       analog_monitor_off_i,
  input wire logic       wakeup_pin_i,
  input wire logic       core_reset_o,
  input wire logic       cpu_clk_en_o,
  input wire logic       core_clk_en_o,
  input wire logic       pll_en_o,
  input wire logic       internal_fast_oscillator_en_o,
  input wire logic       external_fast_oscillator_en_o,
  input wire logic       regulator_en_o,
  input wire logic       regulator_main_mode_o,
  input wire logic       regulator_lowpower_mode_o,
  input wire logic       core_domain_power_o,
  input wire logic       backup_domain_run_o,
  input wire logic [1:0] mode_o
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  a_regulator_standby: assert property (!regulator_en_o |-> mode_o == 2'h3)
    else $error("regulator off outside standby");
  a_standby_off: assert property (mode_o == 2'h3 |-> !(regulator_en_o | core_domain_power_o |
    pll_en_o | internal_fast_oscillator_en_o | external_fast_oscillator_en_o))
    else $error("standby left power or clocks on");
  a_stop_gated: assert property (mode_o == 2'h2 |-> !(core_clk_en_o | pll_en_o |
    internal_fast_oscillator_en_o | external_fast_oscillator_en_o))
    else $error("stop left clocks on");
  a_sleep_cpu: assert property (mode_o == 2'h1 |-> !cpu_clk_en_o && core_clk_en_o)
    else $error("sleep clock gating wrong");
  a_run_main: assert property ((mode_o == 2'h0 && !core_reset_o) [*3] |->
    regulator_main_mode_o && !regulator_lowpower_mode_o)
    else $error("run without main regulator mode");
  a_backup_runs: assert property (backup_domain_run_o)
    else $error("backup domain stopped");
  a_main_reset: assert property (!main_supply_ok_i [*5] |-> core_reset_o)
    else $error("no reset on main supply loss");
  a_analog_reset: assert property ((!analog_supply_ok_i && !analog_monitor_off_i) [*5] |-> core_reset_o)
    else $error("no reset on analog supply loss");
  a_standby_exit: assert property (mode_o == 2'h3 && $rose(wakeup_pin_i) |-> ##[1:12] mode_o != 2'h3)
    else $error("standby not left on wakeup edge");
  a_stop_resume: assert property (mode_o == 2'h2 ##1 mode_o == 2'h0 |-> !core_reset_o)
    else $error("reset on leaving stop");
  c_sleep: cover property (mode_o == 2'h1);
  c_stop_lp: cover property (mode_o == 2'h2 && regulator_lowpower_mode_o);
  c_standby: cover property (mode_o == 2'h3);
endmodule // pms_asserts

//--- bench/pm_core_model.sv
// Behavioural processor core: halts on command, resumes when its clock returns.
// Assumes the supervisor's clock enable and reset outputs.
`timescale 1ns/1ps
module pm_core_model (
  input  wire logic clk_sys_i,
  input  wire logic go_i,
  input  wire logic cpu_clk_en_i,
  input  wire logic core_reset_i,
  output logic      core_halt_o
);
  logic halt_ff;
  logic nxt_halt;
  logic off_ff;
  logic nxt_off;
  // Halt only after software chose the mode
  always_comb begin
    nxt_off  = halt_ff & (off_ff | ~cpu_clk_en_i);
    nxt_halt = halt_ff;
    if (go_i) begin
      nxt_halt = 1'b1;
    end else if (core_reset_i || (off_ff && cpu_clk_en_i)) begin
      nxt_halt = 1'b0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    halt_ff <= nxt_halt;
    off_ff  <= nxt_off;
  end
  assign core_halt_o = halt_ff;
endmodule // pm_core_model

//--- bench/power_mode_supervisor_tb_top.sv
// Bench top: register tasks, mode entry and wake scenarios.
// Assumes the core model and checker in bench/.
`timescale 1ns/1ps
`include "power_mode_params.svh"
module power_mode_supervisor_tb_top;
  logic        clk_sys_i;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        lvl = 1'b1;
  logic        main_ok = 1'b1;
  logic        ana_ok = 1'b1;
  logic        mon_off = 1'b0;
  logic        go = 1'b0;
  logic [23:0] wk = 24'h0;
  logic [31:0] rdata;
  logic [1:0]  mode;
  logic        irq, crst, cpu_en, core_en, pll, osc_i, osc_e, reg_en, reg_mm, reg_lp, dom, bak, halt;
  int          errors = 0;
  int          total_checks = 0;
  int          sb[4] = '{19, 21, 22, 23};
  power_mode_supervisor #(.HOLD(2)) power_mode_supervisor_i (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .irq_o(irq), .main_supply_ok_i(main_ok), .analog_supply_ok_i(ana_ok),
    .supply_level_detector_i(lvl), .analog_monitor_off_i(mon_off), .core_halt_i(halt),
    .external_event_controller_i(wk[15:0]), .comparator_outputs_i(wk[16]), .i2c_wake_i(wk[17]),
    .serial_wake_i(wk[18]), .calendar_alarm_i(wk[19]), .core_irq_i(wk[20]),
    .external_reset_pin_n_i(~wk[21]), .independent_watchdog_i(wk[22]), .wakeup_pin_i(wk[23]),
    .core_reset_o(crst), .cpu_clk_en_o(cpu_en), .core_clk_en_o(core_en), .pll_en_o(pll),
    .internal_fast_oscillator_en_o(osc_i), .external_fast_oscillator_en_o(osc_e),
    .regulator_en_o(reg_en), .regulator_main_mode_o(reg_mm), .regulator_lowpower_mode_o(reg_lp),
    .core_domain_power_o(dom), .backup_domain_run_o(bak), .mode_o(mode));
  pm_core_model pm_core_model_i (.clk_sys_i(clk_sys_i), .go_i(go), .cpu_clk_en_i(cpu_en),
    .core_reset_i(crst), .core_halt_o(halt));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_i);
    wr    <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e, input string n);
    @(posedge clk_sys_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_i);
    rd   <= 1'b0;
    #1;
    chk(n, rdata, e);
  endtask
  task automatic wt(input int s, input logic [1:0] v);
    int i;
    for (i = 0; i < 300 && ((s == 0) ? mode : {1'b0, crst}) !== v; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (((s == 0) ? mode : {1'b0, crst}) !== v) begin
      errors++;
      stop_test();
    end
  endtask
  task automatic enter(input logic [31:0] c, input logic [1:0] m);
    wr_reg(`PM_OFF_CONTROL, c);
    @(posedge clk_sys_i);
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    wt(0, m);
  endtask
  task automatic pulse(input int b);
    @(posedge clk_sys_i);
    wk[b] <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    wk[b] <= 1'b0;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    wt(1, 2'h0);
    chk("reg_en", 32'(reg_en), 32'h1);
    rc(`PM_OFF_CONTROL, 32'h0, "ctl_reset");
    rc(`PM_OFF_STATUS, 32'h2, "state_run");
    rc(4'h2, 32'h0, "unmapped");
    wr_reg(`PM_OFF_CONTROL, 32'h707);
    lvl <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rc(`PM_OFF_IRQ_STATUS, 32'h1, "fall_stat");
    chk("irq_fall", 32'(irq), 32'h1);
    wr_reg(`PM_OFF_IRQ_CLEAR, 32'h1);
    wr_reg(`PM_OFF_CONTROL, 32'h3);
    lvl <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    rc(`PM_OFF_IRQ_STATUS, 32'h2, "rise_stat");
    chk("irq_masked", 32'(irq), 32'h0);
    wr_reg(`PM_OFF_IRQ_CLEAR, 32'h7);
    rc(`PM_OFF_IRQ_STATUS, 32'h0, "cleared");
    enter(32'h50, `PM_REQ_SLEEP);
    chk("sleep_clk", 32'({cpu_en, core_en}), 32'h1);
    pulse(20);
    wt(0, 2'h0);
    chk("sleep_rst", 32'(crst), 32'h0);
    for (int b = 0; b < 20; b++) begin
      enter(32'h60 | ((b % 2) ? 32'h8 : 32'h0), `PM_REQ_STOP);
      chk("stop_reg", 32'({reg_lp, reg_mm}), (b % 2) ? 32'h2 : 32'h1);
      chk("stop_gate", 32'({core_en, pll, osc_i, osc_e, bak}), 32'h1);
      pulse(b);
      wt(0, 2'h0);
      chk("stop_rst", 32'(crst), 32'h0);
    end
    foreach (sb[i]) begin
      enter(32'h70, `PM_REQ_STANDBY);
      chk("standby_off", 32'({reg_en, dom, pll, osc_i, osc_e, bak}), 32'h1);
      @(posedge clk_sys_i);
      wk[sb[i]] <= 1'b1;
      wt(1, 2'h1);
      @(posedge clk_sys_i);
      wk[sb[i]] <= 1'b0;
      wt(1, 2'h0);
      chk("standby_mode", 32'(mode), 32'h0);
      rc(`PM_OFF_CONTROL, 32'h0, "standby_ctl");
    end
    @(posedge clk_sys_i);
    main_ok <= 1'b0;
    wt(1, 2'h1);
    chk("por", 32'(crst), 32'h1);
    @(posedge clk_sys_i);
    main_ok <= 1'b1;
    mon_off <= 1'b1;
    ana_ok  <= 1'b0;
    wt(1, 2'h0);
    repeat (10) @(posedge clk_sys_i);
    #1;
    chk("ana_off", 32'(crst), 32'h0);
    @(posedge clk_sys_i);
    mon_off <= 1'b0;
    wt(1, 2'h1);
    chk("ana_on", 32'(crst), 32'h1);
    stop_test();
  end
endmodule // power_mode_supervisor_tb_top
bind power_mode_supervisor pms_asserts pms_asserts_i (.*);
